//--- hw/serial_flash_clock_gen.sv
// Purpose: Protocol clock generation for a serial flash controller, configured over APB.
// Assumes: Oscillators arrive as one-cycle tick pulses synchronous to CLK; every clock is a tick stream.
// Notes:   Clock outputs are registered; the double-rate output is a one-cycle pulse per period.
//
// Function
// - Host domain on CLK, flash domain on ticks
// - Crystal-PLL, RC direct, RC-PLL paths; crystal recommended
// - Reference select one picks crystal oscillator
// - PLL rate is reference over pre times mult
// - Phase divider divides by 2(mfi+mfn/36)
// - Mux select 26 routes peripheral phase clock
// - Enabled post divider divides; one halves
// - Single-rate clock is half of double-rate
//
// Added by the designer: the address map and register access over APB.
`include "sfcg_params.svh"
module serial_flash_clock_gen #(
	parameter int CREDIT_W = 12,
	parameter int ACC_W    = 14
) (
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        CRYSTAL_OSC_TICK,
	input  wire logic        RC_OSC_TICK,
	output logic             PERIPHERAL_PHASE_CLOCK,
	output logic             DOUBLE_RATE_FLASH_CLOCK,
	output logic             SINGLE_RATE_FLASH_CLOCK
);

	sfcg_pkg::sfcg_pll_cfg_t   pll_cfg;     // PLL settings
	sfcg_pkg::sfcg_phase_cfg_t phase_cfg;   // Phase divider settings
	sfcg_pkg::sfcg_mux_cfg_t   mux_cfg;     // Written mux settings
	sfcg_pkg::sfcg_mux_cfg_t   mux_act;     // Mux settings in effect
	logic                      mux_pend;    // A written mux setting waits
	logic [CREDIT_W-1:0]       credit;      // PLL rate-multiplier credit
	logic                      ref_tick;    // Selected reference tick
	logic                      vco_tick;    // PLL output tick
	logic                      phase_rise;  // Phase divider rising tick
	logic                      phase_level; // Phase divider clock level
	logic                      mux_tick;    // Mux output tick
	logic                      post_rise;   // Post divider rising tick
	logic                      dbl_tick;    // Double-rate rising tick
	logic                      switch_now;  // Mux settings swap this cycle
	logic [ACC_W-1:0]          phase_lim;   // Phase limit in 36ths
	logic [ACC_W-1:0]          post_lim;    // Post limit in halves
	logic [3:0]                pre_eff;     // Pre-divide, zero read as one
	sfcg_pkg::sfcg_path_t      path;        // Path now selected
	logic                      setup;       // APB setup phase
	logic [31:0]               next_rdata;  // Read data for this address
	logic                      next_err;    // Unmapped address

	// Elaboration check: the credit cap and the largest phase limit must fit
	if (CREDIT_W < 9 || ACC_W < 14) begin
		$error("serial_flash_clock_gen: widths too small");
	end

	// Register decode, used for both read and write
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
		addr_hit = (a == ofs);
	endfunction

	assign setup = PSEL && !PENABLE;

	// APB answers in the first access cycle
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= setup;
			PRDATA  <= (setup && !PWRITE) ? next_rdata : 32'h0000_0000;
			PSLVERR <= setup && next_err;
		end
	end

	// Read mux; unmapped addresses read zero and flag an error
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		if (addr_hit(PADDR, `SFCG_OFS_REF_SELECT)) begin
			next_rdata[0] = pll_cfg.ref_select;
		end else if (addr_hit(PADDR, `SFCG_OFS_PLL_DIVIDER)) begin
			next_rdata[`SFCG_PRE_DIV_LSB +: 4] = pll_cfg.pre_divide;
			next_rdata[`SFCG_MULT_LSB +: 8]    = pll_cfg.mult_factor;
		end else if (addr_hit(PADDR, `SFCG_OFS_PHASE_DIVIDER)) begin
			next_rdata[`SFCG_PH_MFI_LSB +: 8] = phase_cfg.int_part;
			next_rdata[`SFCG_PH_MFN_LSB +: 6] = phase_cfg.frac_num;
		end else if (addr_hit(PADDR, `SFCG_OFS_MUX_SELECT)) begin
			next_rdata[4:0] = mux_cfg.source;
		end else if (addr_hit(PADDR, `SFCG_OFS_POST_DIVIDER)) begin
			next_rdata[`SFCG_POST_EN_BIT] = mux_cfg.post_enable;
			next_rdata[3:0]               = mux_cfg.post_divide;
		end else if (addr_hit(PADDR, `SFCG_OFS_STATUS)) begin
			// Live state: path, not-recommended flag, pending swap, clock levels
			next_rdata[1:0] = path;
			next_rdata[2]   = (path != sfcg_pkg::SFCG_PATH_CRYSTAL_PLL);
			next_rdata[3]   = mux_pend;
			next_rdata[4]   = SINGLE_RATE_FLASH_CLOCK;
			next_rdata[5]   = phase_level;
		end else begin
			next_err = 1'b1;
		end
	end

	// PLL and phase settings take effect at once; their ticks simply change rate
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			pll_cfg.ref_select  <= `SFCG_RST_REF;
			pll_cfg.pre_divide  <= `SFCG_RST_PRE_DIV;
			pll_cfg.mult_factor <= `SFCG_RST_MULT;
			phase_cfg.int_part  <= `SFCG_RST_MFI;
			phase_cfg.frac_num  <= `SFCG_RST_MFN;
		end else if (PSEL && PENABLE && PREADY && PWRITE) begin
			if (addr_hit(PADDR, `SFCG_OFS_REF_SELECT)) begin
				pll_cfg.ref_select <= PWDATA[0];
			end
			if (addr_hit(PADDR, `SFCG_OFS_PLL_DIVIDER)) begin
				pll_cfg.pre_divide  <= PWDATA[`SFCG_PRE_DIV_LSB +: 4];
				pll_cfg.mult_factor <= PWDATA[`SFCG_MULT_LSB +: 8];
			end
			if (addr_hit(PADDR, `SFCG_OFS_PHASE_DIVIDER)) begin
				phase_cfg.int_part <= PWDATA[`SFCG_PH_MFI_LSB +: 8];
				phase_cfg.frac_num <= PWDATA[`SFCG_PH_MFN_LSB +: 6];
			end
		end
	end

	// Mux settings are written to a shadow and swapped in later
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			mux_cfg.source      <= `SFCG_RST_MUX;
			mux_cfg.post_enable <= `SFCG_RST_POST_EN;
			mux_cfg.post_divide <= `SFCG_RST_POST_DIV;
		end else if (PSEL && PENABLE && PREADY && PWRITE) begin
			if (addr_hit(PADDR, `SFCG_OFS_MUX_SELECT)) begin
				mux_cfg.source <= PWDATA[4:0];
			end
			if (addr_hit(PADDR, `SFCG_OFS_POST_DIVIDER)) begin
				mux_cfg.post_enable <= PWDATA[`SFCG_POST_EN_BIT];
				mux_cfg.post_divide <= PWDATA[3:0];
			end
		end
	end

	// glitch-free swap: only while the single-rate clock is low and no tick is in flight
	assign switch_now = mux_pend && !SINGLE_RATE_FLASH_CLOCK && !dbl_tick;

	// Active mux settings; a new write during a pending swap simply replaces it
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			mux_act.source      <= `SFCG_RST_MUX;
			mux_act.post_enable <= `SFCG_RST_POST_EN;
			mux_act.post_divide <= `SFCG_RST_POST_DIV;
			mux_pend            <= 1'b0;
		end else if (switch_now) begin
			mux_act  <= mux_cfg;
			mux_pend <= 1'b0;
		end else begin
			mux_pend <= (mux_cfg != mux_act);
		end
	end

	// reference select: one picks the crystal, zero the RC oscillator
	assign ref_tick = (pll_cfg.ref_select == `SFCG_REF_CRYSTAL) ? CRYSTAL_OSC_TICK : RC_OSC_TICK;
	assign pre_eff  = (pll_cfg.pre_divide == 4'h0) ? 4'h1 : pll_cfg.pre_divide;

	// rate multiplier: a reference tick earns mult credits while credit is below the cap, each VCO tick costs pre
	// Limitation: VCO ticks cannot exceed one per CLK, so reference ticks must be slow enough.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			credit   <= '0;
			vco_tick <= 1'b0;
		end else begin
			vco_tick <= (credit >= CREDIT_W'(pre_eff));
			credit   <= credit
			            - ((credit >= CREDIT_W'(pre_eff)) ? CREDIT_W'(pre_eff) : '0)
			            + ((ref_tick && credit < {2'b00, {(CREDIT_W-2){1'b1}}}) ?
			               CREDIT_W'(pll_cfg.mult_factor) : '0);
		end
	end

	// phase divider: toggle every (mfi*36+mfn)/36 input periods
	assign phase_lim = ACC_W'(phase_cfg.int_part) * ACC_W'(`SFCG_FRAC_DENOM) + ACC_W'(phase_cfg.frac_num);

	sfcg_frac_div #(.ACC_W(ACC_W)) u_phase (
		.clk       (CLK),
		.resetn    (RESETN),
		.restart   (1'b0),
		.in_tick   (vco_tick),
		.step      (`SFCG_FRAC_DENOM),
		.limit     (phase_lim),
		.out_level (phase_level),
		.out_rise  (phase_rise)
	);

	// three paths; select 26 takes the phase clock, RC select bypasses the PLL
	always_comb begin
		case (mux_act.source)
			`SFCG_MUX_SRC_PHASE: mux_tick = phase_rise;
			`SFCG_MUX_SRC_RC:    mux_tick = RC_OSC_TICK;
			default:             mux_tick = 1'b0;
		endcase
		if (mux_act.source == `SFCG_MUX_SRC_RC) begin
			path = sfcg_pkg::SFCG_PATH_RC_DIRECT;
		end else if (mux_act.source != `SFCG_MUX_SRC_PHASE) begin
			path = sfcg_pkg::SFCG_PATH_NONE;
		end else if (pll_cfg.ref_select == `SFCG_REF_CRYSTAL) begin
			path = sfcg_pkg::SFCG_PATH_CRYSTAL_PLL;
		end else begin
			path = sfcg_pkg::SFCG_PATH_RC_PLL;
		end
	end

	// post divider period is divide+1 mux periods, so one halves
	assign post_lim = ACC_W'(mux_act.post_divide) + ACC_W'(1);

	sfcg_frac_div #(.ACC_W(ACC_W)) u_post (
		.clk       (CLK),
		.resetn    (RESETN),
		.restart   (switch_now),
		.in_tick   (mux_tick),
		.step      (`SFCG_POST_STEP),
		.limit     (post_lim),
		.out_level (),
		.out_rise  (post_rise)
	);

	assign dbl_tick = mux_act.post_enable ? post_rise : mux_tick;

	// flash-domain clocks are registered outputs; the host side stays on CLK
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			PERIPHERAL_PHASE_CLOCK  <= 1'b0;
			DOUBLE_RATE_FLASH_CLOCK <= 1'b0;
			SINGLE_RATE_FLASH_CLOCK <= 1'b0;
		end else begin
			PERIPHERAL_PHASE_CLOCK  <= phase_level;
			DOUBLE_RATE_FLASH_CLOCK <= dbl_tick;
			if (dbl_tick) begin
				SINGLE_RATE_FLASH_CLOCK <= ~SINGLE_RATE_FLASH_CLOCK;
			end
		end
	end

endmodule

//--- hw/sfcg_frac_div.sv
// Purpose: Fractional tick divider, one output period per limit/step*2 input ticks.
// Assumes: Input ticks are one-cycle pulses, at most one per clock.
// Notes:   Output level toggles when the accumulator crosses the limit.
module sfcg_frac_div #(
	parameter int ACC_W = 14
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             restart,
	input  wire logic             in_tick,
	input  wire logic [7:0]       step,
	input  wire logic [ACC_W-1:0] limit,
	output logic                  out_level,
	output logic                  out_rise
);

	logic [ACC_W-1:0] acc;      // Accumulated fraction of a half period
	logic [ACC_W:0]   next_sum; // Accumulator plus step, one bit wider
	logic [ACC_W-1:0] lim_eff;  // Limit clamped to at least one step

	// Elaboration check: a narrower accumulator would truncate the step
	if (ACC_W < 9) begin
		$error("sfcg_frac_div: ACC_W too small");
	end

	// A limit below the step would need two toggles in one cycle; clamp it
	always_comb begin
		lim_eff  = (limit < ACC_W'(step)) ? ACC_W'(step) : limit;
		next_sum = {1'b0, acc} + (ACC_W + 1)'(step);
	end

	// Accumulate and toggle
	always_ff @(posedge clk) begin
		if (!resetn || restart) begin
			acc       <= '0;
			out_level <= 1'b0;
			out_rise  <= 1'b0;
		end else begin
			out_rise <= 1'b0;
			if (in_tick) begin
				if (next_sum >= {1'b0, lim_eff}) begin
					acc       <= ACC_W'(next_sum - {1'b0, lim_eff});
					out_level <= ~out_level;
					out_rise  <= ~out_level;
				end else begin
					acc <= next_sum[ACC_W-1:0];
				end
			end
		end
	end

endmodule

//--- hw/sfcg_params.svh
// Purpose: Offsets, field positions and reset values of the serial flash clock generator.
// Assumes: Byte addresses on a 32-bit APB, one aligned word per register.
// Notes:   Definitions only.
`ifndef SFCG_PARAMS_SVH
`define SFCG_PARAMS_SVH

// Register byte offsets
`define SFCG_OFS_REF_SELECT     8'h00
`define SFCG_OFS_PLL_DIVIDER    8'h04
`define SFCG_OFS_PHASE_DIVIDER  8'h08
`define SFCG_OFS_MUX_SELECT     8'h0c
`define SFCG_OFS_POST_DIVIDER   8'h10
`define SFCG_OFS_STATUS         8'h14

// Field positions
`define SFCG_PRE_DIV_LSB        0
`define SFCG_MULT_LSB           8
`define SFCG_PH_MFI_LSB         0
`define SFCG_PH_MFN_LSB         8
`define SFCG_POST_EN_BIT        31

// Encodings
`define SFCG_REF_CRYSTAL        1'b1
`define SFCG_MUX_SRC_PHASE      5'h1a
`define SFCG_MUX_SRC_RC         5'h00
`define SFCG_FRAC_DENOM         8'h24
`define SFCG_POST_STEP          8'h02

// Reset values: crystal reference, divide 1, multiply 50, phase 1 + 9/36, mux to phase, post divide 1
`define SFCG_RST_REF            1'b1
`define SFCG_RST_PRE_DIV        4'h1
`define SFCG_RST_MULT           8'h32
`define SFCG_RST_MFI            8'h01
`define SFCG_RST_MFN            6'h09
`define SFCG_RST_MUX            5'h1a
`define SFCG_RST_POST_EN        1'b1
`define SFCG_RST_POST_DIV       4'h1

`endif

//--- hw/sfcg_pkg.sv
// Purpose: Types shared by the serial flash clock generator.
// Assumes: Constants live in sfcg_params.svh.
// Notes:   Types only.
package sfcg_pkg;

	// PLL settings
	typedef struct packed {
		logic       ref_select;   // pll_ref_select
		logic [3:0] pre_divide;   // pll_pre_divide
		logic [7:0] mult_factor;  // integer_mult_factor
	} sfcg_pll_cfg_t;

	// Phase divider settings
	typedef struct packed {
		logic [7:0] int_part;     // integer part
		logic [5:0] frac_num;     // fractional_numerator, in 36ths
	} sfcg_phase_cfg_t;

	// Mux and post divider settings
	typedef struct packed {
		logic [4:0] source;       // mux_source_select
		logic       post_enable;  // post_divider_enable
		logic [3:0] post_divide;  // divide field
	} sfcg_mux_cfg_t;

	// Clock path in use
	typedef enum logic [1:0] {
		SFCG_PATH_CRYSTAL_PLL = 2'b00,
		SFCG_PATH_RC_DIRECT   = 2'b01,
		SFCG_PATH_RC_PLL      = 2'b10,
		SFCG_PATH_NONE        = 2'b11
	} sfcg_path_t;

endpackage

//--- sim/serial_flash_clock_gen_props.sv
// Purpose: Port-level assertions for the serial flash clock generator.
// Assumes: Single CLK domain, synchronous active-low RESETN.
// Notes:   Bound to every instance of the top module.
module sfcg_props (
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        DOUBLE_RATE_FLASH_CLOCK,
	input wire logic        SINGLE_RATE_FLASH_CLOCK
);
	timeunit 1ns;
	timeprecision 1ps;
	// One domain, so one clock and one disable for all
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
	a_ready_one_cycle: assert property (PREADY |=> !PREADY) else $error("ready held too long");
	a_ready_cause: assert property (PREADY |-> $past(PSEL) && !$past(PENABLE)) else $error("ready without setup");
	a_err_only_ready: assert property (PSLVERR |-> PREADY) else $error("error outside access");
	a_err_unmapped: assert property (PREADY && PADDR > 8'h14 |-> PSLVERR && PRDATA == 32'h0) else $error("unmapped ok");
	a_rdata_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0) else $error("read data outside access");
	a_double_pulse: assert property (DOUBLE_RATE_FLASH_CLOCK |=> !DOUBLE_RATE_FLASH_CLOCK) else $error("wide pulse");
	a_single_follows: assert property ($changed(SINGLE_RATE_FLASH_CLOCK) |-> DOUBLE_RATE_FLASH_CLOCK
		|| $past(DOUBLE_RATE_FLASH_CLOCK) || $past(DOUBLE_RATE_FLASH_CLOCK, 2)) else $error("stray toggle");
	a_quiet_release: assert property ($rose(RESETN) |-> !DOUBLE_RATE_FLASH_CLOCK && !PREADY) else $error("busy at release");

	c_read: cover property (PREADY && !PSLVERR);
	c_error: cover property (PSLVERR);
	c_double: cover property (DOUBLE_RATE_FLASH_CLOCK);
endmodule

bind serial_flash_clock_gen sfcg_props i_props (
	.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .DOUBLE_RATE_FLASH_CLOCK(DOUBLE_RATE_FLASH_CLOCK),
	.SINGLE_RATE_FLASH_CLOCK(SINGLE_RATE_FLASH_CLOCK)
);

//--- sim/serial_flash_clock_gen_tb_top.sv
// Purpose: Self-checking bench for the serial flash clock generator.
// Assumes: Crystal tick every 100 cycles, RC tick every 200 cycles.
// Notes:   Rates are judged by counting pulses over fixed windows.
`include "sfcg_params.svh"
module serial_flash_clock_gen_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK, RESETN, PSEL, PENABLE, PWRITE, xtal, rc;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic        PREADY, PSLVERR, phase, dbl, sgl, err;
	int          n_errors, checks_done, xcnt, rcnt, nd, ns, np;
	logic        sgl_q, ph_q;

	serial_flash_clock_gen i_dut (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.CRYSTAL_OSC_TICK(xtal), .RC_OSC_TICK(rc), .PERIPHERAL_PHASE_CLOCK(phase),
		.DOUBLE_RATE_FLASH_CLOCK(dbl), .SINGLE_RATE_FLASH_CLOCK(sgl));

	// 20 MHz host clock
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end

	// Oscillator ticks; the rates keep the VCO below one tick per cycle
	always @(posedge CLK) begin
		xcnt <= (xcnt == 99) ? 0 : xcnt + 1;
		rcnt <= (rcnt == 199) ? 0 : rcnt + 1;
		xtal <= (xcnt == 99);
		rc   <= (rcnt == 199);
	end

	task automatic complete_run();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Exact compare of a design value
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Pulse count compare with a small phase tolerance
	task automatic check_near(input int got, input int exp);
		checks_done++;
		if (got < exp - 2 || got > exp + 2) begin
			n_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer; held until PREADY is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge CLK);
		PSEL <= 1'b1; PWRITE <= wr; PADDR <= a; PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		k = 0;
		do begin
			@(posedge CLK);
			k++;
		end while (PREADY !== 1'b1 && k < 20);
		if (k >= 20) begin
			// Timeout counts as a mismatch and ends the run
			n_errors++;
			complete_run();
		end else begin
			// Answer taken at the edge where PREADY is high, then released
			rd = PRDATA;
			err = PSLVERR;
			PSEL <= 1'b0;
			PENABLE <= 1'b0;
		end
	endtask

	// Read and compare data and error flag
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
		apb(1'b0, a, 32'h0);
		check32(rd, exp);
		check32({31'h0, err}, {31'h0, experr});
	endtask

	// Settle, then count output edges over 1000 cycles
	task automatic count_win();
		repeat (300) @(posedge CLK);
		nd = 0; ns = 0; np = 0;
		repeat (1000) begin
			@(posedge CLK);
			sgl_q = sgl;
			ph_q  = phase;
			#1;
			nd += (dbl === 1'b1);
			ns += (sgl === 1'b1 && sgl_q === 1'b0);
			np += (phase === 1'b1 && ph_q === 1'b0);
		end
	endtask

	initial begin
		{RESETN, PSEL, PENABLE, PWRITE, xtal, rc} = 6'h0;
		PADDR = 8'h0; PWDATA = 32'h0; xcnt = 0; rcnt = 0; n_errors = 0; checks_done = 0;
		repeat (20) @(posedge CLK);
		RESETN <= 1'b1;
		rchk(8'h00, 32'h1, 1'b0);
		rchk(8'h04, 32'h3201, 1'b0);
		rchk(8'h08, 32'h0901, 1'b0);
		rchk(8'h0c, 32'h1a, 1'b0);
		rchk(8'h10, 32'h80000001, 1'b0);
		rchk(8'h14, 32'h0, 1'b0);
		apb(1'b1, 8'h18, 32'hffff);
		check32({31'h0, err}, {31'h0, 1'b1});
		rchk(8'h18, 32'h0, 1'b1);
		// Crystal, 2.5 VCO ticks per phase period, post divide 1
		count_win();
		check_near(np, 200);
		check_near(nd, 100);
		check_near(ns, 50);
		// Post divide 2 gives a double period of three phase periods
		apb(1'b1, 8'h10, 32'h80000002);
		count_win();
		check_near(nd, 67);
		// Post divider off passes the mux output
		apb(1'b1, 8'h10, 32'h1);
		count_win();
		check_near(nd, 200);
		check_near(ns, 100);
		// Pre divide 2 halves the VCO
		apb(1'b1, 8'h04, 32'h3202);
		count_win();
		check_near(np, 100);
		// RC through the PLL, not recommended
		apb(1'b1, 8'h04, 32'h3201);
		apb(1'b1, 8'h00, 32'h0);
		count_win();
		check_near(np, 100);
		apb(1'b0, 8'h14, 32'h0);
		check32({29'h0, rd[2:0]}, 32'h6);
		// Unused mux code stops the flash clocks
		apb(1'b1, 8'h0c, 32'h3);
		count_win();
		check_near(nd, 0);
		apb(1'b0, 8'h14, 32'h0);
		check32({30'h0, rd[1:0]}, 32'h3);
		// RC oscillator straight into the mux, post divider still off
		apb(1'b1, 8'h0c, 32'h0);
		count_win();
		check_near(nd, 5);
		apb(1'b0, 8'h14, 32'h0);
		check32({29'h0, rd[2:0]}, 32'h5);
		// Reset in mid-run brings the mux settings back
		@(posedge CLK);
		RESETN <= 1'b0;
		repeat (5) @(posedge CLK);
		RESETN <= 1'b1;
		rchk(8'h0c, 32'h1a, 1'b0);
		rchk(8'h10, 32'h80000001, 1'b0);
		complete_run();
	end

	// Guard against a hang anywhere
	initial begin
		repeat (20000) @(posedge CLK);
		n_errors++;
		complete_run();
	end
endmodule
